// [clock_sync_pkg.sv]
// Constants, field layouts and carrier types for the clock and frame sync block
package clock_sync_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned FRAME_NS = 125000;
  localparam int unsigned MULTIFRAME_NS = 4000000;
  localparam int unsigned SYSCLK_KHZ = 8192;
  localparam int unsigned PEER_PULSE_NS = 488;
  localparam int unsigned FRAME_SYSCLKS = FRAME_NS * SYSCLK_KHZ / 1000000;
  // Width rounds to the nearest whole system clock period
  localparam int unsigned PEER_SYSCLKS = (PEER_PULSE_NS * SYSCLK_KHZ + 500000) / 1000000;
  localparam int unsigned FRAMES_PER_MULTI = MULTIFRAME_NS / FRAME_NS;
  localparam logic [9:0] FRAME_LAST = 10'(FRAME_SYSCLKS - 1);
  localparam logic [9:0] PEER_WIDTH = 10'(PEER_SYSCLKS);
  localparam logic [4:0] MULTI_LAST = 5'(FRAMES_PER_MULTI - 1);
  localparam logic [9:0] ALIGN_MAX = 10'h3ff;
  // Index of the last source rising edge in each half period of the system clock output
  localparam logic [1:0] OP_HALF_LAST = 2'h1;
  localparam logic [1:0] VCXO_HALF_LAST = 2'h0;
  // Crystal clock 16.384 MHz against the 2.048 MHz reference
  localparam logic [2:0] VCXO_REF_LAST = 3'h7;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] REFSEL_OFFSET = 12'h004;
  localparam logic [11:0] ALIGN_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00c;
  localparam int unsigned REFSEL_LSB = 5;
  localparam int unsigned REFSEL_MSB = 6;
  localparam int unsigned STATUS_MODE_LSB = 0;
  localparam int unsigned STATUS_EXT_BIT = 2;
  localparam int unsigned STATUS_MF_LSB = 3;

  typedef struct packed {
    logic peer_mode;
    logic serial_used;
    logic two_wide;
    logic mask_half;
    logic mask_sysclk;
    logic mask_opclk;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '0;
  localparam logic [1:0] REFSEL_RESET = 2'h0;
  localparam logic [9:0] ALIGN_RESET = 10'h000;

  typedef enum logic [1:0] {
    DELAY_SHORT,
    DELAY_LONG_MASTER,
    DELAY_LONG_SLAVE,
    DELAY_RESERVED
  } delay_mode_e;

  // Pins from outside the clock domain
  typedef struct packed {
    logic por_n;
    logic mode_hi;
    logic mode_lo;
    logic src_sel;
    logic op_clk;
    logic vcxo_clk;
    logic sys_clk;
    logic fsync_n;
    logic peer_sync;
    logic far_ref;
    logic near_ref;
    logic ext_ref;
    logic far_rx_n;
    logic near_rx_n;
  } pins_s;

endpackage : clock_sync_pkg

// [clock_and_frame_sync_control.sv]
// Clock selection, frame sync generation and alignment with an APB register slave
//
// Behaviour
// - A low power-on reset pin returns every register and counter except the pin synchroniser stages to its reset value.
// - The system clock output is the operating clock over four or the crystal clock over two.
// - The operating clock oscillator control, system clock and half-rate clock outputs can each be masked; the crystal control cannot.
// - The 4.096 MHz output is derived from the system clock input.
// - Frame and serial control timing counts periods of the system clock input.
// - The frame sync input and the alignment setting place the frame and multiframe marks.
// - A frame sync output pulse comes every frame, one or two system clock periods wide.
// - With the serial interface unused and no sync input, the own pulse aligns the frame.
// - With its own oscillator the block sends a 488 ns peer sync pulse every frame.
// - In peer clock mode the peer sync input restarts the frame timing.
// - The crystal loop compares against far, near or external reference by a two-bit field.
// - Bit 5 of the reference field picks the far or near receive frame sync.
`timescale 1ns/10ps
module clock_and_frame_sync_control
  import clock_sync_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_reset_n,
  input wire logic delay_mode_sel_lo,
  input wire logic delay_mode_sel_hi,
  input wire logic sysclk_source_select,
  input wire logic operating_clock_in,
  input wire logic vcxo_clock_in,
  input wire logic system_clock_in,
  input wire logic frame_sync_in_n,
  input wire logic peer_sync_in,
  input wire logic far_reference_clock,
  input wire logic near_reference_clock,
  input wire logic external_reference_clock,
  input wire logic far_rx_frame_sync_n,
  input wire logic near_rx_frame_sync_n,
  output logic system_clock_out,
  output logic half_rate_clock_out,
  output logic opclk_vco_control,
  output logic vcxo_control,
  output logic frame_sync_out,
  output logic peer_sync_out,
  output logic rx_frame_sync_n,
  output logic frame_mark,
  output logic multiframe_mark,
  output delay_mode_e delay_mode
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    pins_s meta;
    pins_s sync;
    pins_s prev;
    ctrl_s ctrl;
    logic [1:0] ref_sel;
    logic [9:0] phase_align;
    delay_mode_e mode;
    logic [1:0] src_cnt;
    logic sysclk_q;
    logic half_q;
    logic opclk_ctl;
    logic [2:0] vx_cnt;
    logic vcxo_ctl;
    logic [9:0] frame_cnt;
    logic fso;
    logic pso;
    logic ext_seen;
    logic [9:0] align_cnt;
    logic [4:0] mf_cnt;
    logic fmark;
    logic mmark;
    logic rx_n;
    logic [31:0] rdata;
  } state_s;

  state_s s;
  state_s next_s;
  pins_s pin_in;
  pins_s rise;
  logic ext_fall;
  logic src_rise;
  logic ref_rise;
  logic own_start;
  logic align_ref;
  logic [9:0] frame_next;
  logic [9:0] width;
  logic wr_en;
  logic mapped;

  assign pin_in = '{power_on_reset_n, delay_mode_sel_hi, delay_mode_sel_lo,
                    sysclk_source_select, operating_clock_in, vcxo_clock_in,
                    system_clock_in, frame_sync_in_n, peer_sync_in,
                    far_reference_clock, near_reference_clock,
                    external_reference_clock, far_rx_frame_sync_n,
                    near_rx_frame_sync_n};
  // Edges come from the second synchroniser stage only
  assign rise = s.sync & ~s.prev;
  assign ext_fall = s.prev.fsync_n & ~s.sync.fsync_n;

  // ********************************************************
  // APB slave, zero wait states
  // ********************************************************
  assign pready = 1'b1;
  assign mapped = (paddr == CTRL_OFFSET) || (paddr == REFSEL_OFFSET) ||
                  (paddr == ALIGN_OFFSET) || (paddr == STATUS_OFFSET);
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign prdata = s.rdata;

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    next_s = s;
    src_rise = 1'b0;
    ref_rise = 1'b0;
    own_start = 1'b0;
    align_ref = 1'b0;
    frame_next = s.frame_cnt;
    width = 10'h001;
    next_s.meta = pin_in;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
    if (!s.sync.por_n) begin
      next_s.ctrl = CTRL_RESET;
      next_s.ref_sel = REFSEL_RESET;
      next_s.phase_align = ALIGN_RESET;
      next_s.mode = DELAY_SHORT;
      next_s.src_cnt = '0;
      next_s.sysclk_q = 1'b0;
      next_s.half_q = 1'b0;
      next_s.opclk_ctl = 1'b0;
      next_s.vx_cnt = '0;
      next_s.vcxo_ctl = 1'b0;
      next_s.frame_cnt = '0;
      next_s.fso = 1'b0;
      next_s.pso = 1'b0;
      next_s.ext_seen = 1'b0;
      next_s.align_cnt = '0;
      next_s.mf_cnt = '0;
      next_s.fmark = 1'b0;
      next_s.mmark = 1'b0;
      next_s.rx_n = 1'b1;
      next_s.rdata = '0;
    end else begin
      case ({s.sync.mode_hi, s.sync.mode_lo})
        2'b11: next_s.mode = DELAY_SHORT;
        2'b01: next_s.mode = DELAY_LONG_MASTER;
        2'b00: next_s.mode = DELAY_LONG_SLAVE;
        default: next_s.mode = DELAY_RESERVED;
      endcase
      src_rise = s.sync.src_sel ? rise.op_clk : rise.vcxo_clk;
      if (src_rise) begin
        if (s.src_cnt >= (s.sync.src_sel ? OP_HALF_LAST : VCXO_HALF_LAST)) begin
          next_s.src_cnt = '0;
          next_s.sysclk_q = !s.sysclk_q;
        end else begin
          next_s.src_cnt = s.src_cnt + 2'h1;
        end
      end
      if (rise.sys_clk) begin
        next_s.half_q = !s.half_q;
      end
      // Phase detector: input clock edge leads, divided oscillator edge ends
      if (rise.sys_clk) begin
        next_s.opclk_ctl = 1'b1;
      end else if (src_rise && s.sync.src_sel && next_s.sysclk_q && !s.sysclk_q) begin
        next_s.opclk_ctl = 1'b0;
      end
      case (s.ref_sel)
        2'b00: ref_rise = rise.far_ref;
        2'b01: ref_rise = rise.near_ref;
        default: ref_rise = rise.ext_ref;
      endcase
      if (rise.vcxo_clk) begin
        next_s.vx_cnt = s.vx_cnt + 3'h1;
      end
      // Set wins so a reference edge is never lost
      if (ref_rise) begin
        next_s.vcxo_ctl = 1'b1;
      end else if (rise.vcxo_clk && s.vx_cnt == VCXO_REF_LAST) begin
        next_s.vcxo_ctl = 1'b0;
      end
      if (rise.sys_clk) begin
        frame_next = (s.frame_cnt == FRAME_LAST) ? 10'h000 : s.frame_cnt + 10'h001;
        own_start = (s.frame_cnt == FRAME_LAST);
      end
      if (s.ctrl.peer_mode && rise.peer_sync) begin
        frame_next = 10'h000;
      end
      next_s.frame_cnt = frame_next;
      width = s.ctrl.two_wide ? 10'h002 : 10'h001;
      next_s.fso = frame_next < width;
      next_s.pso = !s.ctrl.peer_mode && (frame_next < PEER_WIDTH);
      if (ext_fall) begin
        next_s.ext_seen = 1'b1;
      end
      align_ref = ext_fall ||
                  (own_start && !s.ctrl.serial_used && !s.ext_seen);
      next_s.fmark = 1'b0;
      next_s.mmark = 1'b0;
      if (align_ref) begin
        next_s.align_cnt = 10'h000;
        // with the serial interface used, outside sync marks a multiframe start
        if (ext_fall && s.ctrl.serial_used) begin
          next_s.mf_cnt = 5'h00;
        end else if (s.mf_cnt == MULTI_LAST) begin
          next_s.mf_cnt = 5'h00;
        end else begin
          next_s.mf_cnt = s.mf_cnt + 5'h01;
        end
      end else if (rise.sys_clk && s.align_cnt != ALIGN_MAX) begin
        next_s.align_cnt = s.align_cnt + 10'h001;
      end
      if (next_s.align_cnt == s.phase_align && next_s.align_cnt != s.align_cnt) begin
        next_s.fmark = 1'b1;
        next_s.mmark = s.ctrl.serial_used && next_s.mf_cnt == 5'h00;
      end else if (align_ref && s.phase_align == 10'h000) begin
        next_s.fmark = 1'b1;
        next_s.mmark = s.ctrl.serial_used && next_s.mf_cnt == 5'h00;
      end
      next_s.rx_n = s.ref_sel[0] ? s.sync.near_rx_n : s.sync.far_rx_n;
      // Register writes
      if (wr_en) begin
        case (paddr)
          CTRL_OFFSET: next_s.ctrl = pwdata[$bits(ctrl_s)-1:0];
          REFSEL_OFFSET: next_s.ref_sel = pwdata[REFSEL_MSB:REFSEL_LSB];
          ALIGN_OFFSET: next_s.phase_align = pwdata[9:0];
          default: next_s.ctrl = s.ctrl;
        endcase
      end
      // Read data captured in the setup phase
      if (psel && !penable) begin
        next_s.rdata = '0;
        case (paddr)
          CTRL_OFFSET: next_s.rdata[$bits(ctrl_s)-1:0] = s.ctrl;
          REFSEL_OFFSET: next_s.rdata[REFSEL_MSB:REFSEL_LSB] = s.ref_sel;
          ALIGN_OFFSET: next_s.rdata[9:0] = s.phase_align;
          STATUS_OFFSET: begin
            next_s.rdata[STATUS_MODE_LSB+:2] = s.mode;
            next_s.rdata[STATUS_EXT_BIT] = s.ext_seen;
            next_s.rdata[STATUS_MF_LSB+:5] = s.mf_cnt;
          end
          default: next_s.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      // Pin stages start at the pull-up level so no false edge follows reset
      s.meta <= '1;
      s.sync <= '1;
      s.prev <= '1;
    end else if (clock_en) begin
      s <= next_s;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // power masks
  assign system_clock_out = s.sysclk_q && !s.ctrl.mask_sysclk;
  assign half_rate_clock_out = s.half_q && !s.ctrl.mask_half;
  assign opclk_vco_control = s.opclk_ctl && !s.ctrl.mask_opclk;
  assign vcxo_control = s.vcxo_ctl;
  assign frame_sync_out = s.fso;
  assign peer_sync_out = s.pso;
  assign rx_frame_sync_n = s.rx_n;
  assign frame_mark = s.fmark;
  assign multiframe_mark = s.mmark;
  assign delay_mode = s.mode;

  // ********************************************************
  // Assertions
  // ********************************************************
  sequence s_run;
    clock_en && s.sync.por_n;
  endsequence
  sequence s_own_frame_end;
    s_run ##0 rise.sys_clk && s.frame_cnt == FRAME_LAST && !(s.ctrl.peer_mode && rise.peer_sync);
  endsequence

  property p_por_clear;
    @(posedge clock) disable iff (!resetn) clock_en && !s.sync.por_n |=> s.frame_cnt == 10'h000 && s.ctrl == CTRL_RESET && !s.fso;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("pin reset did not clear state");

  property p_mode;
    @(posedge clock) disable iff (!resetn) s_run ##0 s.sync.mode_hi && !s.sync.mode_lo |=> delay_mode == DELAY_RESERVED;
  endproperty
  a_mode: assert property (p_mode) else $error("reserved mode code not flagged");

  property p_div;
    @(posedge clock) disable iff (!resetn) s_run ##0 src_rise && s.src_cnt == (s.sync.src_sel ? OP_HALF_LAST : VCXO_HALF_LAST) |=> s.sysclk_q != $past(s.sysclk_q);
  endproperty
  a_div: assert property (p_div) else $error("system clock divider missed a toggle");

  property p_mask;
    @(posedge clock) disable iff (!resetn) s.ctrl.mask_sysclk && s.ctrl.mask_half |-> !system_clock_out && !half_rate_clock_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked clock output active");

  property p_half;
    @(posedge clock) disable iff (!resetn) s_run ##0 rise.sys_clk |=> $changed(s.half_q);
  endproperty
  a_half: assert property (p_half) else $error("half rate clock did not toggle");

  property p_frame;
    @(posedge clock) disable iff (!resetn) s_own_frame_end |=> frame_sync_out && s.frame_cnt == 10'h000;
  endproperty
  a_frame: assert property (p_frame) else $error("frame sync output missing at frame start");

  property p_peer_out;
    @(posedge clock) disable iff (!resetn) peer_sync_out |-> !s.ctrl.peer_mode || $past(!s.ctrl.peer_mode);
  endproperty
  a_peer_out: assert property (p_peer_out) else $error("peer sync sent in peer clock mode");

  property p_peer_in;
    @(posedge clock) disable iff (!resetn) s_run ##0 s.ctrl.peer_mode && rise.peer_sync |=> s.frame_cnt == 10'h000;
  endproperty
  a_peer_in: assert property (p_peer_in) else $error("peer sync did not restart frame");

  property p_ref;
    @(posedge clock) disable iff (!resetn) s_run ##0 s.ref_sel == 2'b00 && rise.far_ref |=> vcxo_control;
  endproperty
  a_ref: assert property (p_ref) else $error("far reference edge not seen by loop");

  property p_rx;
    @(posedge clock) disable iff (!resetn) s_run ##0 s.ref_sel[0] |=> rx_frame_sync_n == $past(s.sync.near_rx_n);
  endproperty
  a_rx: assert property (p_rx) else $error("wrong receive sync selected");

  property p_own_align;
    @(posedge clock) disable iff (!resetn) s_own_frame_end ##0 !s.ctrl.serial_used && !s.ext_seen |=> s.align_cnt == 10'h000;
  endproperty
  a_own_align: assert property (p_own_align) else $error("own frame sync did not align");

  property p_ext_align;
    @(posedge clock) disable iff (!resetn) s_run ##0 ext_fall && s.phase_align == 10'h000 |=> frame_mark && s.align_cnt == 10'h000;
  endproperty
  a_ext_align: assert property (p_ext_align) else $error("frame mark not placed on sync input");

endmodule : clock_and_frame_sync_control

// [peer_model.sv]
// Far-side clock, reference and frame sync sources
`timescale 1ns/10ps
module peer_model (
  input wire logic clock,
  input wire logic [2:0] ref_en,
  input wire logic fs_arm,
  output logic op_clk,
  output logic vcxo_clk,
  output logic sys_clk,
  output logic [2:0] refs,
  output logic fs_n
);
  // ******************************
  // Sources
  // ******************************
  // Slow stand-ins: the block only sees pins below 20 MHz
  int n = 0;
  always @(posedge clock) n <= n + 1;
  assign op_clk = n[1];
  assign vcxo_clk = ~n[1];
  assign sys_clk = ~n[1];
  // Disabled references sit at their pull-up level
  assign refs = ~ref_en | {3{(n % 48) < 24}};
  assign fs_n = !(fs_arm && (n % 4096) < 4);
endmodule : peer_model

// [clock_and_frame_sync_control_test.sv]
// Self-checking bench for the clock and frame sync block
`timescale 1ns/10ps
module clock_and_frame_sync_control_test
  import clock_sync_pkg::*;
;
  // ******************************
  // Signals and monitor
  // ******************************
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, por_n = 1, mode_lo = 1, mode_hi = 1;
  logic src_sel = 1, fs_arm = 0, peer_in = 1, far_rx_n = 1, near_rx_n = 1;
  logic [2:0] ref_en = '0, refs;
  logic op_clk, vcxo_clk, sys_clk, fs_n, sco, hro, oco, vco, fso, pso, rxs_n, fmk, mfm;
  delay_mode_e dmode;
  logic [8:0] mon, seen = '0, prev = '0;
  int failures = 0, n_compared = 0, cyc = 0;
  int per[9], wid[9], hi[9], last[9], nr[9];
  assign mon = {~fs_n, vco, mfm, fmk, pso, fso, oco, hro, sco};
  initial forever #12.5 clock = ~clock;
  peer_model peer_model_i (.clock(clock), .ref_en(ref_en), .fs_arm(fs_arm),
    .op_clk(op_clk), .vcxo_clk(vcxo_clk), .sys_clk(sys_clk), .refs(refs), .fs_n(fs_n));
  clock_and_frame_sync_control clock_and_frame_sync_control_i (.clock(clock),
    .resetn(resetn), .clock_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_reset_n(por_n), .delay_mode_sel_lo(mode_lo), .delay_mode_sel_hi(mode_hi),
    .sysclk_source_select(src_sel), .operating_clock_in(op_clk), .vcxo_clock_in(vcxo_clk),
    .system_clock_in(sys_clk), .frame_sync_in_n(fs_n), .peer_sync_in(peer_in),
    .far_reference_clock(refs[0]), .near_reference_clock(refs[1]),
    .external_reference_clock(refs[2]), .far_rx_frame_sync_n(far_rx_n),
    .near_rx_frame_sync_n(near_rx_n), .system_clock_out(sco), .half_rate_clock_out(hro),
    .opclk_vco_control(oco), .vcxo_control(vco), .frame_sync_out(fso),
    .peer_sync_out(pso), .rx_frame_sync_n(rxs_n), .frame_mark(fmk),
    .multiframe_mark(mfm), .delay_mode(dmode));
  // Rise times, periods and widths in clock cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    prev <= mon;
    for (int i = 0; i < 9; i++) begin
      if (mon[i] === 1'b1 && prev[i] !== 1'b1) begin
        per[i] <= cyc - last[i];
        last[i] <= cyc;
        nr[i] <= nr[i] + 1;
        seen[i] <= 1'b1;
        hi[i] <= 1;
      end else if (mon[i] === 1'b1) hi[i] <= hi[i] + 1;
      else if (prev[i] === 1'b1) wid[i] <= hi[i];
    end
    if (cyc == 80000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
  // ******************************
  // Shared tasks
  // ******************************
  task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask : check
  task automatic near(input string nm, input int x, input int g, input int t);
    n_compared++;
    if (g < x - t || g > x + t) begin
      failures++;
      $display("unexpected %s expected %0d seen %0d", nm, x, g);
    end
  endtask : near
  task automatic wait_rise(input int i, input int lim);
    int n0;
    n0 = nr[i];
    repeat (lim) begin
      @(posedge clock);
      #1;
      if (nr[i] != n0) return;
    end
  endtask : wait_rise
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, '0, q, e);
  endtask : rd
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // ******************************
  // Scenarios
  // ******************************
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(CTRL_OFFSET, q);
    check("ctrl reset", 32'(CTRL_RESET), q);
    check("ready", 32'h1, 32'(pready));
    rd(REFSEL_OFFSET, q);
    check("refsel reset", 32'h0, q);
    wr(ALIGN_OFFSET, 32'hffff_fc05);
    rd(ALIGN_OFFSET, q);
    check("align field", 32'h5, q);
    apb(1'b1, 12'h010, 32'h1, q, e);
    check("unmapped error", 32'h1, 32'(e));
    apb(1'b0, 12'h010, 32'h0, q, e);
    check("unmapped read", 32'h0, q);
  endtask : t_regs
  task automatic t_mode;
    logic [31:0] q;
    logic [1:0] pins [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {mode_hi, mode_lo} <= pins[k];
      repeat (6) @(posedge clock);
      check("delay mode", 32'(k), 32'(dmode));
      rd(STATUS_OFFSET, q);
      check("status mode", 32'(k), 32'(q[1:0]));
    end
    {mode_hi, mode_lo} <= 2'h3;
  endtask : t_mode
  task automatic t_rx;
    for (int k = 0; k < 4; k++) begin
      wr(REFSEL_OFFSET, 32'(k[1]) << REFSEL_LSB);
      far_rx_n <= k[0];
      near_rx_n <= ~k[0];
      repeat (6) @(posedge clock);
      check("rx frame sync", 32'(k[1] ? !k[0] : k[0]), 32'(rxs_n));
    end
    far_rx_n <= 1'b1;
    near_rx_n <= 1'b1;
  endtask : t_rx
  task automatic t_ref;
    for (int s = 0; s < 4; s++) begin
      wr(REFSEL_OFFSET, 32'(s) << REFSEL_LSB);
      for (int r = 0; r < 3; r++) begin
        ref_en <= 3'(1 << r);
        repeat (60) @(posedge clock);
        seen <= '0;
        repeat (100) @(posedge clock);
        check("vcxo control", 32'(s == r || (s > 1 && r == 2)), 32'(seen[7]));
      end
    end
    ref_en <= '0;
  endtask : t_ref
  task automatic t_clk;
    for (int s = 0; s < 2; s++) begin
      src_sel <= s[0];
      repeat (40) @(posedge clock);
      wait_rise(0, 40);
      wait_rise(0, 40);
      near("sysclk out period", s ? 16 : 8, per[0], 0);
    end
    near("half rate period", 8, per[1], 0);
    seen <= '0;
    repeat (60) @(posedge clock);
    check("unmasked outputs", 32'h7, 32'(seen[2:0]));
    wr(CTRL_OFFSET, 32'h7);
    repeat (8) @(posedge clock);
    seen <= '0;
    repeat (60) @(posedge clock);
    check("masked outputs", 32'h0, 32'(seen[2:0]));
    wr(CTRL_OFFSET, 32'h0);
  endtask : t_clk
  task automatic t_align;
    for (int a = 0; a < 2; a++) begin
      wr(ALIGN_OFFSET, a ? 32'd10 : 32'd0);
      wait_rise(3, 5000);
      // With no offset the mark rises on the same edge as the frame sync
      if (a) wait_rise(5, 5000);
      near("mark after own sync", a ? 40 : 0, last[5] - last[3], 6);
    end
    near("frame mark period", 4096, per[5], 0);
  endtask : t_align
  task automatic t_fso;
    wait_rise(3, 5000);
    for (int w = 0; w < 2; w++) begin
      wr(CTRL_OFFSET, w ? 32'h8 : 32'h0);
      wait_rise(3, 5000);
      repeat (12) @(posedge clock);
      near("frame sync width", w ? 8 : 4, wid[3], 0);
    end
    near("frame sync period", 4096, per[3], 0);
    near("peer sync width", 16, wid[4], 0);
    near("peer sync period", 4096, per[4], 0);
  endtask : t_fso
  task automatic t_peer;
    int t;
    wr(CTRL_OFFSET, 32'h20);
    wait_rise(3, 5000);
    seen <= '0;
    wait_rise(3, 5000);
    check("peer sync in peer mode", 32'h0, 32'(seen[4]));
    repeat (1000) @(posedge clock);
    peer_in <= 1'b0;
    repeat (4) @(posedge clock);
    peer_in <= 1'b1;
    t = cyc;
    // Restart opens a frame at once: two pin stages, the frame sync register and the monitor edge
    wait_rise(3, 5000);
    near("restart pulse", 4, last[3] - t, 0);
    wait_rise(3, 5000);
    near("restart to frame sync", 4096, last[3] - t, 12);
    wr(CTRL_OFFSET, 32'h0);
  endtask : t_peer
  task automatic t_ext;
    logic [31:0] q;
    wr(CTRL_OFFSET, 32'h10);
    wr(ALIGN_OFFSET, 32'd5);
    fs_arm <= 1'b1;
    wait_rise(8, 5000);
    repeat (8) @(posedge clock);
    // One pulse only; the next legal one is a whole multiframe away
    fs_arm <= 1'b0;
    wait_rise(5, 200);
    near("mark after sync in", 20, last[5] - last[8], 6);
    check("multiframe with mark", 32'(last[5]), 32'(last[6]));
    rd(STATUS_OFFSET, q);
    check("sync seen", 32'h1, 32'(q[STATUS_EXT_BIT]));
    check("multiframe index", 32'h0, 32'(q[7:3]));
  endtask : t_ext
  task automatic t_por;
    logic [31:0] q;
    wr(CTRL_OFFSET, 32'h3f);
    por_n <= 1'b0;
    repeat (4) @(posedge clock);
    wr(ALIGN_OFFSET, 32'h3);
    check("frame sync in por", 32'h0, 32'({fso, pso}));
    por_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(CTRL_OFFSET, q);
    check("ctrl after por", 32'h0, q);
    rd(ALIGN_OFFSET, q);
    check("align after por", 32'h0, q);
  endtask : t_por
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    t_regs;
    t_mode;
    t_rx;
    t_ref;
    t_clk;
    t_align;
    t_fso;
    t_peer;
    t_ext;
    t_por;
    wrap_up;
  end
endmodule : clock_and_frame_sync_control_test
